// ---- src/pmics_pkg.sv ----
/*
  Constants, field positions and state types for the power monitor serial
  command slave: address pattern, command byte layout, readback sizes.
  Assumes it is compiled before every other design file that imports it.
*/
// Functional notes
// - Answer a 7-bit address with top bits 111 and bottom bits 10.
// - Address select pin levels 00..11 give the two middle address bits.
// - After start, shift in seven address bits MSB first, then direction bit.
// - On match drive data low through the ninth pulse; otherwise stay idle.
// - Bytes take nine pulses; data changes only while the clock is low.
// - First byte after address in a write is the command byte.
// - Address-only write with stop is a presence check; address still acknowledged.
// - Command write is address, acknowledge, command byte, acknowledge, stop.
// - Command MSB 0 is a command byte; MSB 1 is an extended register write.
// - C0 converts voltage continuously; early reads are acknowledged and return zeros.
// - C1 converts voltage once, self-clears; reads refused until it completes.
// - C2 converts current continuously; early reads are acknowledged and return zeros.
// - C3 converts current once, self-clears; reads refused until it completes.
// - C6 set makes following reads return the alert status byte.
// - One 12-bit converter shared by voltage and current through a multiplexer.
// - Slave only, serial clock up to 400 kHz.
// - Combined readback is V[11:4], I[11:4], then V[3:0] over I[3:0].
// - Single readback is R[11:4], then R[3:0] over a zero nibble.

package pmics_pkg;

  // ===========================================================================
  // Address pattern.
  localparam logic [2:0] ADDR_HIGH_BITS = 3'h7;
  localparam logic [1:0] ADDR_LOW_BITS  = 2'h2;

  // ===========================================================================
  // Command byte field positions.
  localparam int CMD_V_REPEAT_BIT = 0;
  localparam int CMD_V_ONCE_BIT   = 1;
  localparam int CMD_I_REPEAT_BIT = 2;
  localparam int CMD_I_ONCE_BIT   = 3;
  localparam int CMD_DIVIDER_BIT  = 4;
  localparam int CMD_STATUS_BIT   = 6;
  localparam int CMD_EXTENDED_BIT = 7;
  localparam logic CMD_FIELD_RESET = 1'b0;

  // ===========================================================================
  // Byte framing and readback sizes.
  localparam int ADC_BITS               = 12;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [1:0] LAST_BYTE_PAIR = 2'h1;
  localparam logic [1:0] LAST_BYTE_TRIO = 2'h2;
  localparam int SCL_MAX_KHZ            = 400;
  localparam int CLK_KHZ                = 20000;
  localparam int SCL_MIN_HALF_CLKS      = CLK_KHZ / (2 * SCL_MAX_KHZ);

  // ===========================================================================
  // State types.
  typedef enum logic [2:0] {
    BUS_IDLE     = 3'h0,
    BUS_ADDR     = 3'h1,
    BUS_ADDR_ACK = 3'h3,
    BUS_CMD      = 3'h2,
    BUS_CMD_ACK  = 3'h6,
    BUS_TX       = 3'h7,
    BUS_MACK     = 3'h5,
    BUS_IGNORE   = 3'h4
  } pmics_bus_state_type;

  typedef enum logic [1:0] {
    ADC_IDLE = 2'h0,
    ADC_BUSY = 2'h1,
    ADC_HAND = 2'h3
  } pmics_adc_state_type;

endpackage : pmics_pkg

// ---- src/pmics_sync.sv ----
/*
  Two flip-flop level synchroniser of parameterised width.
  Assumes each bit is an independent level or toggle from another domain.
*/
`timescale 1ns/1ns

module pmics_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous input and synchronised output.
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage, so no logic sees a metastable bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // pmics_sync

// ---- src/pmics_top.sv ----
/*
  Serial bus command slave of a supply monitor: address match, command byte
  handling and two or three byte readback, plus the conversion sequencer on
  the converter clock. Assumes SCL and SDA arrive as pins sampled on CLK, the
  address select pin is already resolved to two logic levels, and the
  converter runs on ADC_CLK and answers each start with one ADC_DONE pulse.
*/
`timescale 1ns/1ns

module pmics_top (
  // System clock and synchronous reset.
  input  wire logic                           CLK,
  input  wire logic                           RST,
  // Serial bus pins; data is open drain.
  input  wire logic                           SCL_I,
  input  wire logic                           SDA_I,
  output logic                                SDA_O,
  output logic                                SDA_OE,
  // Address select pin level and alert status from the supervisor.
  input  wire logic [1:0]                     ADR_LEVEL,
  input  wire logic [7:0]                     ALERT_STATUS,
  // Converter side; start and channel select on its own clock, divider select on CLK.
  input  wire logic                           ADC_CLK,
  output logic                                ADC_START,
  output logic                                ADC_CURRENT_SEL,
  output logic                                VOLT_DIVIDER_SELECT,
  input  wire logic                           ADC_DONE,
  input  wire logic [pmics_pkg::ADC_BITS-1:0] ADC_DATA
);
  import pmics_pkg::*;

  // ===========================================================================
  // Pin synchronisers and edge detection.
  logic [4:0] pin_s;
  logic       scl_d;
  logic       sda_d;
  logic       res_tgl;
  logic       res_d;

  // Left out of reset so the copies track the idle-high pins and no false edge follows reset.
  pmics_sync #(.WIDTH(5)) u_pin_sync (
    .clk  (CLK),
    .rst  (1'b0),
    .din  ({res_tgl, ADR_LEVEL, SDA_I, SCL_I}),
    .dout (pin_s)
  );

  wire logic       scl_s     = pin_s[0];
  wire logic       sda_s     = pin_s[1];
  wire logic [1:0] adr_s     = pin_s[3:2];
  wire logic       res_s     = pin_s[4];
  wire logic       scl_rise  = scl_s & ~scl_d;
  wire logic       scl_fall  = ~scl_s & scl_d;
  wire logic       bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire logic       bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // Delayed copies read only the second synchroniser stage.
  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      res_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      res_d <= res_s;
    end
  end

  // ===========================================================================
  // Bus engine.
  pmics_bus_state_type state;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_sh;
  logic [7:0]  tx_sh;
  logic [7:0]  tx_byte;
  logic [1:0]  byte_idx;
  logic        dir_read;
  logic        cmd_first;
  logic [1:0]  adr_bits;
  logic        read_block;
  logic        volt_convert_repeat;
  logic        amp_convert_repeat;
  logic        volt_once;
  logic        amp_once;
  logic        volt_pend;
  logic        amp_pend;
  logic        status_select;
  logic        read_volt;
  logic        read_amp;
  logic [11:0] volt_res;
  logic [11:0] amp_res;

  wire logic addr_match = rx_sh[7:1] == {ADDR_HIGH_BITS, adr_bits, ADDR_LOW_BITS};
  wire logic byte_end   = scl_fall && (bit_cnt == BITS_PER_BYTE);
  wire logic cmd_take   = (state == BUS_CMD_ACK) && scl_fall && cmd_first
                          && !rx_sh[CMD_EXTENDED_BIT];
  assign read_block = volt_pend | amp_pend;
  assign SDA_O      = 1'b0;

  // The select pin is followed only between transfers, so a mid-frame change cannot split one.
  always_ff @(posedge CLK) begin
    if (RST) begin
      adr_bits <= 2'h0;
    end else if (state == BUS_IDLE) begin
      adr_bits <= adr_s;
    end
  end

  // Start and stop override any state; ack drives only change after a clock fall.
  always_ff @(posedge CLK) begin
    if (RST) begin
      state     <= BUS_IDLE;
      bit_cnt   <= 4'h0;
      rx_sh     <= 8'h00;
      tx_sh     <= 8'h00;
      byte_idx  <= 2'h0;
      dir_read  <= 1'b0;
      cmd_first <= 1'b0;
      SDA_OE    <= 1'b0;
    end else if (bus_start) begin
      state    <= BUS_ADDR;
      bit_cnt  <= 4'h0;
      byte_idx <= 2'h0;
      SDA_OE   <= 1'b0;
    end else if (bus_stop) begin
      state  <= BUS_IDLE;
      SDA_OE <= 1'b0;
    end else begin
      case (state)
        BUS_ADDR, BUS_CMD: begin
          if (scl_rise) begin
            rx_sh   <= {rx_sh[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            bit_cnt <= 4'h0;
            if (state == BUS_CMD) begin
              SDA_OE <= 1'b1;
              state  <= BUS_CMD_ACK;
            end else if (addr_match && !(rx_sh[0] && read_block)) begin
              SDA_OE   <= 1'b1;
              dir_read <= rx_sh[0];
              state    <= BUS_ADDR_ACK;
            end else begin
              state <= BUS_IGNORE;
            end
          end
        end
        BUS_ADDR_ACK: begin
          if (scl_fall) begin
            cmd_first <= ~dir_read;
            byte_idx  <= 2'h1;
            if (dir_read) begin
              SDA_OE <= ~tx_byte[7];
              tx_sh  <= {tx_byte[6:0], 1'b0};
              state  <= BUS_TX;
            end else begin
              SDA_OE <= 1'b0;
              state  <= BUS_CMD;
            end
          end
        end
        BUS_CMD_ACK: begin
          if (scl_fall) begin
            SDA_OE    <= 1'b0;
            cmd_first <= 1'b0;
            state     <= BUS_CMD;
          end
        end
        BUS_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            SDA_OE  <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= BUS_MACK;
          end else if (scl_fall) begin
            SDA_OE <= ~tx_sh[7];
            tx_sh  <= {tx_sh[6:0], 1'b0};
          end
        end
        BUS_MACK: begin
          if (scl_rise && sda_s) begin
            state <= BUS_IGNORE;
          end else if (scl_fall) begin
            SDA_OE   <= ~tx_byte[7];
            tx_sh    <= {tx_byte[6:0], 1'b0};
            byte_idx <= (byte_idx == 2'h3) ? 2'h3 : byte_idx + 2'h1;
            state    <= BUS_TX;
          end
        end
        default: begin
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end

  // Readback byte for the current index; status mode repeats the alert byte, otherwise bytes past the last read as zero.
  always_comb begin
    tx_byte = 8'h00;
    if (status_select) begin
      tx_byte = ALERT_STATUS;
    end else if (read_volt && read_amp) begin
      case (byte_idx)
        2'h0:    tx_byte = volt_res[11:4];
        2'h1:    tx_byte = amp_res[11:4];
        2'h2:    tx_byte = {volt_res[3:0], amp_res[3:0]};
        default: tx_byte = 8'h00;
      endcase
    end else if (byte_idx == 2'h0) begin
      tx_byte = read_amp ? amp_res[11:4] : volt_res[11:4];
    end else if (byte_idx == LAST_BYTE_PAIR) begin
      tx_byte = {(read_amp ? amp_res[3:0] : volt_res[3:0]), 4'h0};
    end
  end

  // ===========================================================================
  // Command register; C5 is ignored and extended writes leave it untouched.
  always_ff @(posedge CLK) begin
    if (RST) begin
      volt_convert_repeat <= CMD_FIELD_RESET;
      amp_convert_repeat  <= CMD_FIELD_RESET;
      volt_once           <= CMD_FIELD_RESET;
      amp_once            <= CMD_FIELD_RESET;
      VOLT_DIVIDER_SELECT <= CMD_FIELD_RESET;
      status_select       <= CMD_FIELD_RESET;
      read_volt           <= 1'b0;
      read_amp            <= 1'b0;
    end else if (cmd_take) begin
      volt_convert_repeat <= rx_sh[CMD_V_REPEAT_BIT];
      volt_once           <= rx_sh[CMD_V_ONCE_BIT];
      amp_convert_repeat  <= rx_sh[CMD_I_REPEAT_BIT];
      amp_once            <= rx_sh[CMD_I_ONCE_BIT];
      VOLT_DIVIDER_SELECT <= rx_sh[CMD_DIVIDER_BIT];
      status_select       <= rx_sh[CMD_STATUS_BIT];
      read_volt <= rx_sh[CMD_V_REPEAT_BIT] | rx_sh[CMD_V_ONCE_BIT];
      read_amp  <= rx_sh[CMD_I_REPEAT_BIT] | rx_sh[CMD_I_ONCE_BIT];
    end else begin
      volt_once <= 1'b0;
      amp_once  <= 1'b0;
    end
  end

  // ===========================================================================
  // Results from the converter domain; a new arrival wins over a command clear.
  logic [12:0] res_word;
  wire logic   res_new = res_s ^ res_d;

  always_ff @(posedge CLK) begin
    if (RST) begin
      volt_res  <= 12'h000;
      amp_res   <= 12'h000;
      volt_pend <= 1'b0;
      amp_pend  <= 1'b0;
    end else begin
      if (cmd_take && (rx_sh[CMD_V_REPEAT_BIT] | rx_sh[CMD_V_ONCE_BIT])) begin
        volt_res  <= 12'h000;
        volt_pend <= rx_sh[CMD_V_ONCE_BIT];
      end
      if (cmd_take && (rx_sh[CMD_I_REPEAT_BIT] | rx_sh[CMD_I_ONCE_BIT])) begin
        amp_res  <= 12'h000;
        amp_pend <= rx_sh[CMD_I_ONCE_BIT];
      end
      if (res_new && !res_word[12]) begin
        volt_res  <= res_word[11:0];
        volt_pend <= 1'b0;
      end
      if (res_new && res_word[12]) begin
        amp_res  <= res_word[11:0];
        amp_pend <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // Converter domain: one shared converter, channels alternate when both run.
  logic [5:0] adc_s;
  logic       adc_rst;
  logic       v_tgl;
  logic       i_tgl;
  logic       v_tgl_d;
  logic       i_tgl_d;
  logic       pend_v;
  logic       pend_i;
  logic       last_amp;
  pmics_adc_state_type adc_state;

  // Once requests cross as toggles so a single-cycle request cannot be missed.
  always_ff @(posedge CLK) begin
    if (RST) begin
      v_tgl <= 1'b0;
      i_tgl <= 1'b0;
    end else begin
      v_tgl <= v_tgl ^ volt_once;
      i_tgl <= i_tgl ^ amp_once;
    end
  end

  pmics_sync #(.WIDTH(1)) u_rst_sync (
    .clk  (ADC_CLK),
    .rst  (1'b0),
    .din  (RST),
    .dout (adc_rst)
  );

  pmics_sync #(.WIDTH(6)) u_adc_sync (
    .clk  (ADC_CLK),
    .rst  (adc_rst),
    .din  ({res_d, i_tgl, v_tgl, VOLT_DIVIDER_SELECT, amp_convert_repeat,
            volt_convert_repeat}),
    .dout (adc_s)
  );

  wire logic want_v   = pend_v | adc_s[0];
  wire logic want_i   = pend_i | adc_s[1];
  wire logic pick_amp = want_i && (!want_v || !last_amp);

  // Result word holds still until the system side echoes the toggle back.
  always_ff @(posedge ADC_CLK) begin
    if (adc_rst) begin
      adc_state       <= ADC_IDLE;
      ADC_START       <= 1'b0;
      ADC_CURRENT_SEL <= 1'b0;
      res_word        <= 13'h0000;
      res_tgl         <= 1'b0;
      pend_v          <= 1'b0;
      pend_i          <= 1'b0;
      last_amp        <= 1'b0;
      v_tgl_d         <= 1'b0;
      i_tgl_d         <= 1'b0;
    end else begin
      v_tgl_d <= adc_s[3];
      i_tgl_d <= adc_s[4];
      if (adc_s[3] ^ v_tgl_d) begin
        pend_v <= 1'b1;
      end
      if (adc_s[4] ^ i_tgl_d) begin
        pend_i <= 1'b1;
      end
      ADC_START <= 1'b0;
      case (adc_state)
        ADC_IDLE: begin
          if (want_v || want_i) begin
            ADC_START       <= 1'b1;
            ADC_CURRENT_SEL <= pick_amp;
            adc_state       <= ADC_BUSY;
          end
        end
        ADC_BUSY: begin
          if (ADC_DONE) begin
            res_word  <= {ADC_CURRENT_SEL, ADC_DATA};
            res_tgl   <= ~res_tgl;
            last_amp  <= ADC_CURRENT_SEL;
            adc_state <= ADC_HAND;
            if (ADC_CURRENT_SEL && !(adc_s[4] ^ i_tgl_d)) begin
              pend_i <= 1'b0;
            end
            if (!ADC_CURRENT_SEL && !(adc_s[3] ^ v_tgl_d)) begin
              pend_v <= 1'b0;
            end
          end
        end
        ADC_HAND: begin
          if (adc_s[5] == res_tgl) begin
            adc_state <= ADC_IDLE;
          end
        end
        default: begin
          adc_state <= ADC_IDLE;
        end
      endcase
    end
  end

  // ===========================================================================
  // Checks on the bus engine, command handling and converter start.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence addr_byte_done_s;
    (state == BUS_ADDR) && byte_end && !bus_start && !bus_stop;
  endsequence

  sequence ack_slot_s;
    (state == BUS_ADDR_ACK) && SDA_OE;
  endsequence

  addr_ack_a: assert property (addr_byte_done_s ##0 (addr_match && !rx_sh[0])
    |=> ack_slot_s) else $error("Matching write address not acknowledged.");
  addr_miss_a: assert property (addr_byte_done_s ##0 !addr_match
    |=> (state == BUS_IGNORE) && !SDA_OE) else $error("Foreign address answered.");
  once_refuse_a: assert property (addr_byte_done_s ##0 (rx_sh[0] && read_block)
    |=> !SDA_OE) else $error("Read acknowledged while a single conversion runs.");
  ack_hold_a: assert property (ack_slot_s ##0 (!scl_fall && !bus_start && !bus_stop)
    |=> SDA_OE) else $error("Acknowledge released before clock fall.");
  start_reset_a: assert property (bus_start |=> (state == BUS_ADDR) && (bit_cnt == 4'h0)
    && !SDA_OE) else $error("Start did not restart the address byte.");
  divider_load_a: assert property (cmd_take |=> VOLT_DIVIDER_SELECT
    == $past(rx_sh[CMD_DIVIDER_BIT])) else $error("Divider select not loaded.");
  ext_keep_a: assert property ((state == BUS_CMD_ACK) && scl_fall && rx_sh[CMD_EXTENDED_BIT]
    |=> $stable(status_select) && $stable(read_volt)) else $error("Extended write hit command.");
  once_clear_a: assert property (volt_once |=> !volt_once || $past(cmd_take))
    else $error("Single voltage bit did not self-clear.");
  repeat_zero_a: assert property (cmd_take && rx_sh[CMD_I_REPEAT_BIT] && !res_new
    |=> amp_res == 12'h000) else $error("Current result not zeroed on start.");
  adc_one_a: assert property (@(posedge ADC_CLK) disable iff (adc_rst)
    ADC_START |=> !ADC_START [*2]) else $error("Converter started twice.");

endmodule // pmics_top

// ---- tb/pmics_master.sv ----
/*
  Behavioural serial bus master driving the supply monitor slave.
  Assumes the bench resolves the pulled-up data wire and supplies CLK.
*/
`timescale 1ns/1ns

module pmics_master (
  // Timing reference and resolved data wire.
  input  wire logic CLK,
  input  wire logic sda_wire,
  // Serial clock and data pull-down enable.
  output logic      scl,
  output logic      sda_oe
);
  // Half serial clock period in CLK cycles; 25 gives 400 kHz.
  localparam int HALF = 25;

  // ===========================================================================
  // Bus primitives.
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  // Waits whole cycles, then steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #2;
  endtask

  // Data falls while the clock is high to open a transfer.
  task automatic start();
    sda_oe = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_oe = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask

  // One clock pulse; data moves only well inside the low phase.
  task automatic bit_io(input logic v, output logic r);
    tick(4);
    sda_oe = !v;
    tick(HALF - 4);
    scl = 1'b1;
    tick(HALF / 2);
    r = sda_wire;
    tick(HALF - HALF / 2);
    scl = 1'b0;
  endtask

  // Eight bits, most significant first, then the acknowledge pulse.
  task automatic xfer(input logic [7:0] d, input logic v9, output logic [7:0] q,
                      output logic r9);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(v9, r9);
  endtask

  // Data low in the low phase, then rising while the clock is high.
  task automatic stop();
    tick(4);
    sda_oe = 1'b1;
    tick(HALF - 4);
    scl = 1'b1;
    tick(HALF);
    sda_oe = 1'b0;
    tick(HALF);
  endtask
endmodule // pmics_master

// ---- tb/tb_pmics_top.sv ----
/*
  Self-checking bench for the supply monitor serial slave: master model,
  converter model on its own clock, a table of cases, then edge cases.
  Assumes the design package and the master model are compiled first.
*/
`timescale 1ns/1ns

module tb_pmics_top;
  import pmics_pkg::*;

  typedef struct {
    logic [1:0] lvl;
    logic [7:0] cmd;
    logic [7:0] e0;
    logic [7:0] e1;
    logic [7:0] e2;
  } pmics_row_type;

  logic        clk, rst, scl, m_oe, sda_o, sda_oe, sda_wire;
  logic        adc_clk, adc_start, adc_sel, div_sel, adc_done, sel;
  logic [1:0]  adr_level;
  logic [7:0]  alert;
  logic [11:0] adc_data;
  int          errors, n_compared, cdly, cnt;

  // Single, combined, status and divider cases.
  pmics_row_type rows [7] = '{
    '{2'h0, 8'h01, 8'ha5, 8'hc0, 8'h00},
    '{2'h1, 8'h04, 8'h3b, 8'h70, 8'h00},
    '{2'h2, 8'h05, 8'ha5, 8'h3b, 8'hc7},
    '{2'h3, 8'h02, 8'ha5, 8'hc0, 8'h00},
    '{2'h0, 8'h08, 8'h3b, 8'h70, 8'h00},
    '{2'h1, 8'h40, 8'h96, 8'h96, 8'h96},
    '{2'h2, 8'h35, 8'ha5, 8'h3b, 8'hc7}
  };

  // Open-drain data wire with a pull-up.
  assign sda_wire = !m_oe && !(sda_oe && !sda_o);

  // ===========================================================================
  // Clocks, models and the design.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The converter clock starts off phase so no edge lines up with CLK.
  initial begin
    adc_clk = 1'b0;
    #13;
    forever #40 adc_clk = ~adc_clk;
  end

  // Converter answers after cdly cycles; idle data toggles so stale words fail.
  always @(posedge adc_clk) begin
    if (adc_start) begin
      sel = adc_sel;
      cnt = cdly;
    end
    #2;
    adc_done = 1'b0;
    adc_data = ~adc_data;
    if (cnt == 1) begin
      adc_done = 1'b1;
      adc_data = sel ? 12'h3b7 : 12'ha5c;
    end
    if (cnt > 0) cnt = cnt - 1;
  end

  pmics_master pmics_master_inst (.CLK(clk), .sda_wire(sda_wire), .scl(scl), .sda_oe(m_oe));

  pmics_top pmics_top_inst (
    .CLK                 (clk),
    .RST                 (rst),
    .SCL_I               (scl),
    .SDA_I               (sda_wire),
    .SDA_O               (sda_o),
    .SDA_OE              (sda_oe),
    .ADR_LEVEL           (adr_level),
    .ALERT_STATUS        (alert),
    .ADC_CLK             (adc_clk),
    .ADC_START           (adc_start),
    .ADC_CURRENT_SEL     (adc_sel),
    .VOLT_DIVIDER_SELECT (div_sel),
    .ADC_DONE            (adc_done),
    .ADC_DATA            (adc_data)
  );

  // ===========================================================================
  // Checking and transfer tasks.
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Write of n bytes; ak is high only if every byte was acknowledged.
  task automatic wr(input logic [6:0] a, input int n, input logic [7:0] c0,
                    input logic [7:0] c1, output logic ak);
    logic [7:0] q;
    logic       r;
    pmics_master_inst.start();
    pmics_master_inst.xfer({a, 1'b0}, 1'b1, q, r);
    ak = !r;
    if (ak && n > 0) pmics_master_inst.xfer(c0, 1'b1, q, r);
    if (n > 0) ak = ak && !r;
    if (ak && n > 1) pmics_master_inst.xfer(c1, 1'b1, q, r);
    if (n > 1) ak = ak && !r;
    pmics_master_inst.stop();
  endtask

  // Three-byte read, last byte not acknowledged, then compare.
  task automatic rdchk(input logic [6:0] a, input logic ak_w, input logic [7:0] e0,
                       input logic [7:0] e1, input logic [7:0] e2);
    logic [7:0] b [3];
    logic       r;
    logic       na;
    pmics_master_inst.start();
    pmics_master_inst.xfer({a, 1'b1}, 1'b1, b[0], na);
    // A refused read is still clocked through, so a silent slave reads as all ones.
    for (int i = 0; i < 3; i++) begin
      pmics_master_inst.xfer(8'hff, i == 2, b[i], r);
    end
    pmics_master_inst.stop();
    chk({7'h00, !na}, {7'h00, ak_w});
    if (ak_w) begin
      chk(b[0], e0);
      chk(b[1], e1);
      chk(b[2], e2);
    end else begin
      chk(b[0], 8'hff);
    end
  endtask

  // ===========================================================================
  // Main sequence.
  initial begin
    logic       ak;
    logic [6:0] a;
    rst = 1'b1;
    adr_level = 2'h0;
    alert = 8'h96;
    adc_done = 1'b0;
    adc_data = 12'h000;
    cdly = 3;
    cnt = 0;
    errors = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    #2;
    chk({7'h00, sda_oe}, 8'h00);
    chk({7'h00, sda_o}, 8'h00);
    chk({7'h00, div_sel}, 8'h00);
    rst = 1'b0;
    pmics_master_inst.tick(6);
    foreach (rows[k]) begin
      adr_level = rows[k].lvl;
      a = {ADDR_HIGH_BITS, rows[k].lvl, ADDR_LOW_BITS};
      pmics_master_inst.tick(5);
      wr(a, 1, rows[k].cmd, 8'h00, ak);
      chk({7'h00, ak}, 8'h01);
      pmics_master_inst.tick(300);
      chk({7'h00, div_sel}, {7'h00, rows[k].cmd[4]});
      rdchk(a, 1'b1, rows[k].e0, rows[k].e1, rows[k].e2);
    end
    // A foreign address is ignored; presence and extended writes leave settings alone.
    wr({ADDR_HIGH_BITS, 2'h3, ADDR_LOW_BITS}, 1, 8'h01, 8'h00, ak);
    chk({7'h00, ak}, 8'h00);
    wr(a, 0, 8'h00, 8'h00, ak);
    chk({7'h00, ak}, 8'h01);
    wr(a, 2, 8'h81, 8'h00, ak);
    chk({7'h00, ak}, 8'h01);
    chk({7'h00, div_sel}, 8'h01);
    rdchk(a, 1'b1, 8'ha5, 8'h3b, 8'hc7);
    // Slow converter: single requests refuse reads until their result lands.
    wr(a, 1, 8'h00, 8'h00, ak);
    pmics_master_inst.tick(100);
    cdly = 2000;
    for (int k = 0; k < 2; k++) begin
      wr(a, 1, k ? 8'h08 : 8'h02, 8'h00, ak);
      rdchk(a, 1'b0, 8'h00, 8'h00, 8'h00);
      pmics_master_inst.tick(8000);
      rdchk(a, 1'b1, k ? 8'h3b : 8'ha5, k ? 8'h70 : 8'hc0, 8'h00);
    end
    // Continuous channels read as zero until their first fresh result.
    wr(a, 1, 8'h05, 8'h00, ak);
    rdchk(a, 1'b1, 8'h00, 8'h00, 8'h00);
    // Mid-run reset clears the divider choice and the slave answers again afterwards.
    wr(a, 1, 8'h10, 8'h00, ak);
    chk({7'h00, div_sel}, 8'h01);
    rst = 1'b1;
    pmics_master_inst.tick(12);
    chk({7'h00, div_sel}, 8'h00);
    chk({7'h00, sda_oe}, 8'h00);
    rst = 1'b0;
    pmics_master_inst.tick(6);
    wr(a, 0, 8'h00, 8'h00, ak);
    chk({7'h00, ak}, 8'h01);
    wrap_up();
  end

  // Watchdog well beyond the expected run of about 60000 cycles.
  initial begin
    #4_000_000;
    errors++;
    wrap_up();
  end
endmodule // tb_pmics_top
